// [hdl/vuf_regs.sv]
// The AHB-Lite register port was left to the implementer.
`timescale 1ns/1ps
module vuf_regs
  import vuf_pkg::*;
#(
  parameter bit RX_TAG_INSERT_OPTION = 1'b1,
  parameter bit TX_TAG_INSERT_OPTION = 1'b1,
  parameter bit TX_TAG_STRIP_OPTION = 1'b1,
  parameter bit RX_TAG_STRIP_OPTION = 1'b1,
  parameter bit RX_TAG_TRANSLATE_OPTION = 1'b1,
  parameter bit EXTENDED_MCAST_FILTER_OPTION = 1'b1
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire vuf_dst_t rx_dst,
  input wire vuf_type_t rx_type,
  input wire vuf_type_t tx_type,
  output vuf_tag_t rx_tag_out,
  output logic rx_tag_insert_en,
  output logic rx_verdict_valid,
  output logic rx_discard,
  output logic rx_vlan_valid,
  output logic rx_is_vlan,
  output logic tx_vlan_valid,
  output logic tx_is_vlan,
  output logic use_internal_unicast
);

  ////////////////////////////////////////////////////////////////////////////
  // Build options seen by the logic
  localparam bit VLAN_OPTS = RX_TAG_INSERT_OPTION | TX_TAG_INSERT_OPTION | TX_TAG_STRIP_OPTION
                             | RX_TAG_STRIP_OPTION | RX_TAG_TRANSLATE_OPTION;

  ////////////////////////////////////////////////////////////////////////////
  // Storage
  logic [31:0] rx_vlan_tag_value;
  logic [31:0] unicast_match_low;
  logic [VUF_UNI_HIGH_W-1:0] unicast_match_high;
  logic [31:0] vlan_type_word_zero;
  logic [31:0] vlan_type_word_one;
  logic ext_filter_enable;
  logic [VUF_CNT_W-1:0] discard_count;

  // Bus state
  logic acc;
  logic dph_wr;
  logic dph_rd;
  logic rd_pend;
  logic [7:0] dph_addr;

  // Datapath terms
  logic ext_active;
  logic [47:0] unicast_match_address;
  logic ucast_drop;
  logic rx_tag_protocol_id_hit;
  logic tx_tag_protocol_id_hit;

  ////////////////////////////////////////////////////////////////////////////
  // Read mux
  function automatic logic [31:0] read_word(input logic [7:0] a);
    logic [31:0] w;
    w = VUF_RST_WORD;
    case (a)
      VUF_ADDR_RX_TAG: w = rx_vlan_tag_value;
      VUF_ADDR_UNI_LOW: w = unicast_match_low;
      VUF_ADDR_UNI_HIGH: w = {VUF_RST_HALF, unicast_match_high};
      VUF_ADDR_TAG_PROTOCOL_ID_W0: w = vlan_type_word_zero;
      VUF_ADDR_TAG_PROTOCOL_ID_W1: w = vlan_type_word_one;
      VUF_ADDR_CTRL: w[VUF_CTRL_EXT_EN_BIT] = ext_filter_enable;
      VUF_ADDR_STATUS: begin
        w[VUF_CNT_W-1:0] = discard_count;
        w[VUF_STAT_EXT_ACT_BIT] = ext_active;
        w[VUF_STAT_VLAN_OPT_BIT] = VLAN_OPTS;
        w[VUF_STAT_TAG_OPT_BIT] = RX_TAG_INSERT_OPTION;
      end
      default: w = VUF_RST_WORD;
    endcase
    return w;
  endfunction : read_word

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite address phase
  assign acc = hsel && (htrans == VUF_HTRANS_NONSEQ) && hready;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dph_wr <= 1'b0;
      dph_rd <= 1'b0;
      dph_addr <= 8'h00;
    end else if (hready) begin
      dph_wr <= acc && hwrite && (hsize == VUF_HSIZE_WORD);
      dph_rd <= acc && !hwrite;
      if (acc) begin
        dph_addr <= haddr[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data and wait state after a write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hrdata <= VUF_RST_WORD;
      hreadyout <= 1'b1;
      rd_pend <= 1'b0;
    end else if (rd_pend) begin
      hrdata <= read_word(dph_addr);
      hreadyout <= 1'b1;
      rd_pend <= 1'b0;
    end else if (acc && !hwrite) begin
      if (dph_wr) begin
        rd_pend <= 1'b1;
        hreadyout <= 1'b0;
      end else begin
        hrdata <= read_word(haddr[7:0]);
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hresp <= VUF_HRESP_OKAY;
    end else begin
      hresp <= VUF_HRESP_OKAY;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_vlan_tag_value <= VUF_RST_WORD;
      unicast_match_low <= VUF_RST_WORD;
      unicast_match_high <= VUF_RST_HALF;
      vlan_type_word_zero <= VUF_RST_WORD;
      vlan_type_word_one <= VUF_RST_WORD;
      ext_filter_enable <= 1'b0;
    end else if (dph_wr) begin
      case (dph_addr)
        VUF_ADDR_RX_TAG: rx_vlan_tag_value <= hwdata;
        VUF_ADDR_UNI_LOW: unicast_match_low <= hwdata;
        VUF_ADDR_UNI_HIGH: unicast_match_high <= hwdata[VUF_UNI_HIGH_W-1:0];
        VUF_ADDR_TAG_PROTOCOL_ID_W0: vlan_type_word_zero <= hwdata;
        VUF_ADDR_TAG_PROTOCOL_ID_W1: vlan_type_word_one <= hwdata;
        VUF_ADDR_CTRL: ext_filter_enable <= hwdata[VUF_CTRL_EXT_EN_BIT];
        default: ext_filter_enable <= ext_filter_enable;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Unicast filter
  // option and enable both needed
  assign ext_active = EXTENDED_MCAST_FILTER_OPTION && ext_filter_enable;
  assign unicast_match_address = {unicast_match_high, unicast_match_low};

  vuf_ucast_check u_ucast (
    .filter_active(ext_active),
    .stored_addr(unicast_match_address),
    .dest_addr(rx_dst.addr),
    .discard(ucast_drop)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_verdict_valid <= 1'b0;
      rx_discard <= 1'b0;
      use_internal_unicast <= 1'b1;
    end else begin
      rx_verdict_valid <= rx_dst.valid;
      rx_discard <= rx_dst.valid && ucast_drop;
      use_internal_unicast <= !ext_active;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      discard_count <= VUF_RST_HALF;
    end else if (rx_dst.valid && ucast_drop && (discard_count != VUF_CNT_MAX)) begin
      discard_count <= discard_count + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // VLAN recognition on both paths
  vuf_tag_protocol_id_match u_rx_tag_protocol_id (
    .word_zero(vlan_type_word_zero),
    .word_one(vlan_type_word_one),
    .field(rx_type.field),
    .hit(rx_tag_protocol_id_hit)
  );

  vuf_tag_protocol_id_match u_tx_tag_protocol_id (
    .word_zero(vlan_type_word_zero),
    .word_one(vlan_type_word_one),
    .field(tx_type.field),
    .hit(tx_tag_protocol_id_hit)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_vlan_valid <= 1'b0;
      rx_is_vlan <= 1'b0;
      tx_vlan_valid <= 1'b0;
      tx_is_vlan <= 1'b0;
    end else begin
      rx_vlan_valid <= rx_type.valid;
      tx_vlan_valid <= tx_type.valid;
      rx_is_vlan <= VLAN_OPTS && rx_type.valid && rx_tag_protocol_id_hit;
      tx_is_vlan <= VLAN_OPTS && tx_type.valid && tx_tag_protocol_id_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive tag for insertion
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_tag_out <= vuf_tag_t'(VUF_RST_WORD);
      rx_tag_insert_en <= 1'b0;
    end else begin
      rx_tag_insert_en <= RX_TAG_INSERT_OPTION;
      // tag word handed to the inserter
      rx_tag_out <= RX_TAG_INSERT_OPTION ? vuf_tag_t'(rx_vlan_tag_value) : vuf_tag_t'(VUF_RST_WORD);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  a_tag_store: assert property (
    @(posedge clk) disable iff (rst)
    (dph_wr && dph_addr == VUF_ADDR_RX_TAG)
      |=> (rx_vlan_tag_value == $past(hwdata)) ##1 (rx_tag_out == $past(hwdata, 2) || !RX_TAG_INSERT_OPTION)
  ) else $error("receive tag write not stored");

  a_tag_gate: assert property (
    @(posedge clk) disable iff (rst)
    !RX_TAG_INSERT_OPTION |=> (!rx_tag_insert_en && rx_tag_out == vuf_tag_t'(VUF_RST_WORD))
  ) else $error("receive tag used without option");

  a_tag_insert: assert property (
    @(posedge clk) disable iff (rst)
    RX_TAG_INSERT_OPTION |=> (rx_tag_insert_en && rx_tag_out == $past(rx_vlan_tag_value))
  ) else $error("inserted tag differs from register");

  a_high_reserved: assert property (
    @(posedge clk) disable iff (rst)
    (dph_rd && hreadyout && dph_addr == VUF_ADDR_UNI_HIGH) |-> (hrdata[31:16] == VUF_RST_HALF)
  ) else $error("reserved unicast bits not zero");

  a_addr_split: assert property (
    @(posedge clk) disable iff (rst)
    (dph_rd && hreadyout && dph_addr == VUF_ADDR_UNI_LOW) |-> (hrdata == unicast_match_address[31:0])
  ) else $error("low unicast word misplaced");

  a_mismatch_drop: assert property (
    @(posedge clk) disable iff (rst)
    (rx_dst.valid && ext_active && !rx_dst.addr[0] && rx_dst.addr != unicast_match_address)
      |=> (rx_verdict_valid && rx_discard)
  ) else $error("mismatching unicast frame kept");

  a_match_keep: assert property (
    @(posedge clk) disable iff (rst)
    (rx_dst.valid && rx_dst.addr == unicast_match_address) |=> (rx_verdict_valid && !rx_discard)
  ) else $error("matching frame dropped");

  a_filter_off: assert property (
    @(posedge clk) disable iff (rst)
    (rx_dst.valid && !ext_active) |=> (!rx_discard && use_internal_unicast)
  ) else $error("frame dropped while filter inactive");

  a_tag_protocol_id_hit: assert property (
    @(posedge clk) disable iff (rst)
    (VLAN_OPTS && tx_type.valid && tx_type.field == vlan_type_word_one[31:16]) |=> (tx_vlan_valid && tx_is_vlan)
  ) else $error("tag protocol id three not recognised");

  a_tag_protocol_id_slot: assert property (
    @(posedge clk) disable iff (rst)
    (VLAN_OPTS && rx_type.valid && rx_type.field == vlan_type_word_zero[15:0]) |=> rx_is_vlan
  ) else $error("tag protocol id zero not recognised");

  a_tag_protocol_id_unused: assert property (
    @(posedge clk) disable iff (rst)
    (!VLAN_OPTS && rx_type.valid) |=> (rx_vlan_valid && !rx_is_vlan)
  ) else $error("VLAN recognised without option");

  a_read_wait: assert property (
    @(posedge clk) disable iff (rst)
    (acc && !hwrite && dph_wr) |=> !hreadyout ##1 (hreadyout && hrdata == read_word(dph_addr))
  ) else $error("read after write not delayed one cycle");

  a_low_write: assert property (
    @(posedge clk) disable iff (rst)
    (dph_wr && dph_addr == VUF_ADDR_UNI_LOW) |=> (unicast_match_low == $past(hwdata))
  ) else $error("low unicast word not stored");

  a_high_write: assert property (
    @(posedge clk) disable iff (rst)
    (dph_wr && dph_addr == VUF_ADDR_UNI_HIGH)
      |=> (unicast_match_high == VUF_UNI_HIGH_W'($past(hwdata)))
  ) else $error("high unicast word not stored");

  a_tag_protocol_id_store: assert property (
    @(posedge clk) disable iff (rst)
    (dph_wr && dph_addr == VUF_ADDR_TAG_PROTOCOL_ID_W0) |=> (vlan_type_word_zero == $past(hwdata))
  ) else $error("tag protocol id word not stored");

  a_tag_protocol_id_miss: assert property (
    @(posedge clk) disable iff (rst)
    (VLAN_OPTS && rx_type.valid
      && rx_type.field != vlan_type_word_zero[15:0] && rx_type.field != vlan_type_word_zero[31:16]
      && rx_type.field != vlan_type_word_one[15:0] && rx_type.field != vlan_type_word_one[31:16])
      |=> (rx_vlan_valid && !rx_is_vlan)
  ) else $error("unknown type field taken as VLAN");

  a_use_internal: assert property (
    @(posedge clk) disable iff (rst)
    ext_active |=> !use_internal_unicast
  ) else $error("internal unicast selected while filter active");

  a_narrow_write: assert property (
    @(posedge clk) disable iff (rst)
    (acc && hwrite && hsize != VUF_HSIZE_WORD) |=> ##1 $stable(rx_vlan_tag_value)
  ) else $error("narrow write changed receive tag");

  a_verdict_pulse: assert property (
    @(posedge clk) disable iff (rst)
    !rx_dst.valid |=> !rx_verdict_valid
  ) else $error("verdict without a frame");

endmodule : vuf_regs

// [hdl/vuf_pkg.sv]
// Contract
// - The receive tag register only takes effect when the receive tag insertion option is built in as 1.
// - An inserted receive tag is the 32-bit receive tag value, placed right after the source address.
// - The receive tag holds the protocol id in 31-16, priority in 15-13, format bit 12 and VLAN id in 11-0, all RW.
// - The two unicast match registers apply only when the extended filter is built in and enabled.
// - With the extended filter active, unicast frames whose destination differs from the stored address are dropped.
// - Address bits 31:0 sit in the low register and bits 47:32 in bits 15-0 of the high register.
// - The first address byte on the wire sits in the least significant byte of the register pair.
// - Bits 31-16 of the high unicast register ignore writes and read as zero.
// - Four 16-bit protocol ids are held two per word, value 0 low and value 1 high, then values 2 and 3.
// - The protocol id words are used whenever any VLAN tag, strip or translate option is built in as 1.
package vuf_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam logic [7:0] VUF_ADDR_RX_TAG = 8'h1c;
  localparam logic [7:0] VUF_ADDR_UNI_LOW = 8'h20;
  localparam logic [7:0] VUF_ADDR_UNI_HIGH = 8'h24;
  localparam logic [7:0] VUF_ADDR_TAG_PROTOCOL_ID_W0 = 8'h28;
  localparam logic [7:0] VUF_ADDR_TAG_PROTOCOL_ID_W1 = 8'h2c;
  localparam logic [7:0] VUF_ADDR_CTRL = 8'h40;
  localparam logic [7:0] VUF_ADDR_STATUS = 8'h44;

  ////////////////////////////////////////////////////////////////////////////
  // Fields and reset values
  localparam logic [31:0] VUF_RST_WORD = 32'h0000_0000;
  localparam logic [15:0] VUF_RST_HALF = 16'h0000;
  localparam int VUF_UNI_HIGH_W = 16;
  localparam int VUF_TAG_PROTOCOL_ID_W = 16;
  localparam int VUF_CTRL_EXT_EN_BIT = 0;
  localparam int VUF_CNT_W = 16;
  localparam int VUF_STAT_EXT_ACT_BIT = 16;
  localparam int VUF_STAT_VLAN_OPT_BIT = 17;
  localparam int VUF_STAT_TAG_OPT_BIT = 18;
  localparam logic [VUF_CNT_W-1:0] VUF_CNT_MAX = 16'hffff;

  ////////////////////////////////////////////////////////////////////////////
  // Bus encodings
  localparam logic [1:0] VUF_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] VUF_HSIZE_WORD = 3'h2;
  localparam logic VUF_HRESP_OKAY = 1'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic [15:0] tag_protocol_id;
    logic [2:0] priority_field;
    logic canonical_format_bit;
    logic [11:0] vlan_identifier;
  } vuf_tag_t;

  typedef struct packed {
    logic valid;
    logic [47:0] addr;
  } vuf_dst_t;

  typedef struct packed {
    logic valid;
    logic [15:0] field;
  } vuf_type_t;

endpackage : vuf_pkg

// [hdl/vuf_tag_protocol_id_match.sv]
`timescale 1ns/1ps
module vuf_tag_protocol_id_match
  import vuf_pkg::*;
(
  input wire logic [31:0] word_zero,
  input wire logic [31:0] word_one,
  input wire logic [15:0] field,
  output logic hit
);

  logic [3:0] slot_hit;

  assign slot_hit[0] = (field == word_zero[VUF_TAG_PROTOCOL_ID_W-1:0]);
  assign slot_hit[1] = (field == word_zero[2*VUF_TAG_PROTOCOL_ID_W-1:VUF_TAG_PROTOCOL_ID_W]);
  assign slot_hit[2] = (field == word_one[VUF_TAG_PROTOCOL_ID_W-1:0]);
  assign slot_hit[3] = (field == word_one[2*VUF_TAG_PROTOCOL_ID_W-1:VUF_TAG_PROTOCOL_ID_W]);

  assign hit = |slot_hit;

endmodule : vuf_tag_protocol_id_match

// [hdl/vuf_ucast_check.sv]
`timescale 1ns/1ps
module vuf_ucast_check
  import vuf_pkg::*;
(
  input wire logic filter_active,
  input wire logic [47:0] stored_addr,
  input wire logic [47:0] dest_addr,
  output logic discard
);

  logic is_unicast;

  // group bit of first wire byte
  assign is_unicast = ~dest_addr[0];

  assign discard = filter_active && is_unicast && (dest_addr != stored_addr);

endmodule : vuf_ucast_check

// [sim/vlan_unicast_filter_regs_tb.sv]
`timescale 1ns/1ps
module vlan_unicast_filter_regs_tb;
  import vuf_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = VUF_HSIZE_WORD;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, rx_tag_insert_en, rx_verdict_valid, rx_discard;
  logic rx_vlan_valid, rx_is_vlan, tx_vlan_valid, tx_is_vlan, use_internal_unicast;
  logic [31:0] hrdata;
  vuf_dst_t rx_dst = '0;
  vuf_type_t rx_type = '0;
  vuf_type_t tx_type = '0;
  vuf_tag_t rx_tag_out;
  int errors = 0;
  int num_checks = 0;
  logic [31:0] q;
  logic [31:0] q_off;
  logic [31:0] off_hrdata;
  logic off_hreadyout, off_hresp, off_tag_en, off_verdict, off_discard, off_internal;
  logic off_rx_vv, off_rx_vlan, off_tx_vv, off_tx_vlan;
  vuf_tag_t off_tag;
  logic [15:0] ids [4] = '{16'h8100, 16'h9100, 16'h9200, 16'h88a8};

  always #5 clk = ~clk;

  vuf_regs dut (
    .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .rx_dst(rx_dst), .rx_type(rx_type), .tx_type(tx_type), .rx_tag_out(rx_tag_out),
    .rx_tag_insert_en(rx_tag_insert_en), .rx_verdict_valid(rx_verdict_valid), .rx_discard(rx_discard),
    .rx_vlan_valid(rx_vlan_valid), .rx_is_vlan(rx_is_vlan), .tx_vlan_valid(tx_vlan_valid),
    .tx_is_vlan(tx_is_vlan), .use_internal_unicast(use_internal_unicast)
  );

  // Copy built with every option off, in lock step on the same bus
  vuf_regs #(
    .RX_TAG_INSERT_OPTION(1'b0), .TX_TAG_INSERT_OPTION(1'b0), .TX_TAG_STRIP_OPTION(1'b0),
    .RX_TAG_STRIP_OPTION(1'b0), .RX_TAG_TRANSLATE_OPTION(1'b0), .EXTENDED_MCAST_FILTER_OPTION(1'b0)
  ) dut_off (
    .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(off_hreadyout), .hresp(off_hresp),
    .hrdata(off_hrdata), .rx_dst(rx_dst), .rx_type(rx_type), .tx_type(tx_type), .rx_tag_out(off_tag),
    .rx_tag_insert_en(off_tag_en), .rx_verdict_valid(off_verdict), .rx_discard(off_discard),
    .rx_vlan_valid(off_rx_vv), .rx_is_vlan(off_rx_vlan), .tx_vlan_valid(off_tx_vv),
    .tx_is_vlan(off_tx_vlan), .use_internal_unicast(off_internal)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checking and bus tasks
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task complete_run;
    $display("Checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run

  // Registered outputs, so the value read right at the edge is the sampled one
  task wait_ready;
    do @(posedge clk); while (hreadyout !== 1'b1);
  endtask : wait_ready

  task addr_phase(input logic [7:0] a, input logic w, input logic [2:0] s);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= VUF_HTRANS_NONSEQ;
    hwrite <= w;
    hsize <= s;
  endtask : addr_phase

  task end_addr;
    hsel <= 1'b0;
    htrans <= 2'h0;
  endtask : end_addr

  task ahb_write_sz(input logic [7:0] a, input logic [31:0] d, input logic [2:0] s);
    addr_phase(a, 1'b1, s);
    wait_ready();
    end_addr();
    hwdata <= d;
    wait_ready();
  endtask : ahb_write_sz

  task ahb_write(input logic [7:0] a, input logic [31:0] d);
    ahb_write_sz(a, d, VUF_HSIZE_WORD);
  endtask : ahb_write

  task ahb_read(input logic [7:0] a, output logic [31:0] d);
    addr_phase(a, 1'b0, VUF_HSIZE_WORD);
    wait_ready();
    end_addr();
    wait_ready();
    d = hrdata;
    q_off = off_hrdata;
    chk("hready_off", 32'h1, {31'h0, off_hreadyout});
    chk("hresp_off", {31'h0, VUF_HRESP_OKAY}, {31'h0, off_hresp});
    chk("hresp", {31'h0, VUF_HRESP_OKAY}, {31'h0, hresp});
  endtask : ahb_read

  task rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    ahb_read(a, q);
    chk(name, exp, q);
  endtask : rd_chk

  // Read address phase overlaps the write data phase
  task wr_rd(input logic [7:0] wa, input logic [31:0] d, input logic [7:0] ra, output logic [31:0] r);
    addr_phase(wa, 1'b1, VUF_HSIZE_WORD);
    wait_ready();
    hwdata <= d;
    addr_phase(ra, 1'b0, VUF_HSIZE_WORD);
    wait_ready();
    end_addr();
    wait_ready();
    r = hrdata;
  endtask : wr_rd

  task send_dst(input logic [47:0] a, input logic exp);
    rx_dst <= {1'b1, a};
    @(posedge clk);
    rx_dst <= '0;
    @(posedge clk);
    chk("verdict_valid", 32'h1, {31'h0, rx_verdict_valid});
    chk("discard", {31'h0, exp}, {31'h0, rx_discard});
    chk("verdict_off", 32'h1, {31'h0, off_verdict});
    chk("discard_off", 32'h0, {31'h0, off_discard});
  endtask : send_dst

  task send_type(input logic tx, input logic [15:0] f, input logic exp);
    if (tx) begin
      tx_type <= {1'b1, f};
    end else begin
      rx_type <= {1'b1, f};
    end
    @(posedge clk);
    rx_type <= '0;
    tx_type <= '0;
    @(posedge clk);
    chk("vlan_valid", 32'h1, {31'h0, tx ? tx_vlan_valid : rx_vlan_valid});
    chk("is_vlan", {31'h0, exp}, {31'h0, tx ? tx_is_vlan : rx_is_vlan});
    chk("vlan_valid_off", 32'h1, {31'h0, tx ? off_tx_vv : off_rx_vv});
    chk("is_vlan_off", 32'h0, {31'h0, tx ? off_tx_vlan : off_rx_vlan});
  endtask : send_type

  ////////////////////////////////////////////////////////////////////////////
  // Tests
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk("tag_insert_en", 32'h1, {31'h0, rx_tag_insert_en});
    chk("use_internal", 32'h1, {31'h0, use_internal_unicast});
    chk("tag_insert_en_off", 32'h0, {31'h0, off_tag_en});
    chk("use_internal_off", 32'h1, {31'h0, off_internal});
    rd_chk("rx_tag", VUF_ADDR_RX_TAG, VUF_RST_WORD);
    rd_chk("uni_low", VUF_ADDR_UNI_LOW, VUF_RST_WORD);
    rd_chk("uni_high", VUF_ADDR_UNI_HIGH, VUF_RST_WORD);
    rd_chk("tag_protocol_id_w0", VUF_ADDR_TAG_PROTOCOL_ID_W0, VUF_RST_WORD);
    rd_chk("tag_protocol_id_w1", VUF_ADDR_TAG_PROTOCOL_ID_W1, VUF_RST_WORD);
    rd_chk("ctrl", VUF_ADDR_CTRL, VUF_RST_WORD);
    rd_chk("status", VUF_ADDR_STATUS, 32'h0006_0000);
    chk("status_off", 32'h0, q_off);
    rd_chk("unmapped", 8'h30, 32'h0);
    $display("Test reset_values done");
    ahb_write(VUF_ADDR_RX_TAG, 32'h88a8_b123);
    repeat (2) @(posedge clk);
    chk("tag_tag_protocol_id", 32'h88a8, {16'h0, rx_tag_out.tag_protocol_id});
    chk("tag_prio", 32'h5, {29'h0, rx_tag_out.priority_field});
    chk("tag_cfi", 32'h1, {31'h0, rx_tag_out.canonical_format_bit});
    chk("tag_vid", 32'h123, {20'h0, rx_tag_out.vlan_identifier});
    chk("tag_off", 32'h0, off_tag);
    rd_chk("rx_tag", VUF_ADDR_RX_TAG, 32'h88a8_b123);
    ahb_write_sz(VUF_ADDR_RX_TAG, 32'h0, 3'h0);
    rd_chk("rx_tag_narrow", VUF_ADDR_RX_TAG, 32'h88a8_b123);
    ahb_write(VUF_ADDR_UNI_HIGH, 32'hffff_ffff);
    rd_chk("uni_high", VUF_ADDR_UNI_HIGH, 32'h0000_ffff);
    wr_rd(VUF_ADDR_UNI_LOW, 32'hddcc_bbaa, VUF_ADDR_UNI_LOW, q);
    chk("uni_low_stall", 32'hddcc_bbaa, q);
    ahb_write(VUF_ADDR_UNI_HIGH, 32'h1234_ffee);
    rd_chk("uni_high", VUF_ADDR_UNI_HIGH, 32'h0000_ffee);
    $display("Test register_access done");
    send_dst(48'h0000_0000_0002, 1'b0);
    ahb_write(VUF_ADDR_CTRL, 32'h1); // core taken as promiscuous
    repeat (2) @(posedge clk);
    chk("use_internal", 32'h0, {31'h0, use_internal_unicast});
    chk("use_internal_off", 32'h1, {31'h0, off_internal});
    send_dst(48'hffee_ddcc_bbaa, 1'b0);
    send_dst(48'hffee_ddcc_bba2, 1'b1);
    send_dst(48'hffee_ddcc_bbab, 1'b0);
    send_dst(48'haaee_ddcc_bbaa, 1'b1);
    rd_chk("status", VUF_ADDR_STATUS, 32'h0007_0002);
    chk("status_off", 32'h0, q_off);
    ahb_write(VUF_ADDR_CTRL, 32'h0);
    repeat (2) @(posedge clk);
    chk("use_internal", 32'h1, {31'h0, use_internal_unicast});
    send_dst(48'haaee_ddcc_bbaa, 1'b0);
    $display("Test unicast_filter done");
    ahb_write(VUF_ADDR_TAG_PROTOCOL_ID_W0, 32'h9100_8100);
    ahb_write(VUF_ADDR_TAG_PROTOCOL_ID_W1, 32'h88a8_9200);
    for (int t = 0; t < 2; t++) begin
      for (int i = 0; i < 4; i++) begin
        send_type(t[0], ids[i], 1'b1);
      end
      send_type(t[0], 16'h0800, 1'b0);
      send_type(t[0], 16'h9101, 1'b0);
    end
    $display("Test vlan_match done");
    complete_run();
  end

  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    $display("Error watchdog expected done seen timeout");
    complete_run();
  end
endmodule : vlan_unicast_filter_regs_tb
